// File: compare_unit_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the compare pulse unit
// Assumes: 25 MHz reference clock, AXI4-Lite register window of 48 bytes
// Notes:   definitions only
`ifndef COMPARE_UNIT_CFG_SVH
`define COMPARE_UNIT_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CONTROL         8'h00
`define OFS_START_INDEX     8'h04
`define OFS_AXIS_POSITION   8'h08
`define OFS_REMAINING       8'h0C
`define OFS_CAPTURE_CONTROL 8'h10
`define OFS_CAPTURE_COUNT   8'h14
`define OFS_OUT_RESOLUTION  8'h18
`define OFS_OUT_DIVISOR     8'h1C
`define OFS_ARRAY_INDEX     8'h20
`define OFS_ARRAY_DATA      8'h24
`define OFS_STATUS          8'h28
`define OFS_USER_OUTPUT     8'h2C

// ****************************************
// control word fields
// ****************************************
`define CTL_ENABLE_BIT      0
`define CTL_CYCLIC_BIT      1
`define CTL_ARM_CAPTURE_BIT 2
`define CTL_CLEAR_AXIS_BIT  3
`define CTL_SOURCE_LSB      4
`define CTL_POLARITY_BIT    8
`define CTL_TASK_LSB        12
`define CTL_DURATION_LSB    16
`define CAP_ENABLE_BIT      0
`define CAP_SOURCE_LSB      4
`define STS_DONE_BIT        2

// ****************************************
// reset values, constants, timing
// ****************************************
`define RST_WORD            32'h0000_0000
`define ARRAY_DEPTH_DEF     800
`define TASK_FIRST          7'h32
`define TASK_SECOND         7'h3C
`define CLK_HZ              25000000
`define PULSE_UNIT_MS       1
`define MS_CYCLES_DEF       ((`CLK_HZ / 1000) * `PULSE_UNIT_MS)
`define COUNTS_PER_REV_DEF  10000
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: compare_unit_pkg.sv
// Purpose: shared types of the compare pulse unit
// Assumes: nothing beyond the cfg header
// Notes:   one-hot sequencer states
package compare_unit_pkg;

   typedef enum logic [2:0]
   {
      SEQ_IDLE     = 3'b001,
      SEQ_RUN      = 3'b010,
      SEQ_FINISHED = 3'b100
   } seq_state_e;

   typedef enum logic [3:0]
   {
      SRC_CAPTURE = 4'h0,
      SRC_AUX     = 4'h1,
      SRC_PULSE   = 4'h2,
      SRC_MOTOR   = 4'h3
   } axis_source_e;

endpackage : compare_unit_pkg

// File: position_compare_pulse_unit.sv
// Purpose: high-speed position compare with timed pulse output and encoder pulse scaling
// Assumes: position inputs come from logic on REF_CLK; motor position moves at most one count per cycle
// Notes:   registers over AXI4-Lite, one write and one read outstanding
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`include "compare_unit_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module position_compare_pulse_unit
   import compare_unit_pkg::*;
#(
   parameter int unsigned MS_CYCLES      = `MS_CYCLES_DEF,
   parameter int unsigned ARRAY_DEPTH    = `ARRAY_DEPTH_DEF,
   parameter int unsigned COUNTS_PER_REV = `COUNTS_PER_REV_DEF
)
(
   // clock, reset, enable
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   // axi4-lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // position sources
   input  wire logic [31:0] CAPTURE_AXIS_POS,
   input  wire logic [31:0] AUX_ENCODER_POS,
   input  wire logic [31:0] PULSE_COMMAND_POS,
   input  wire logic [31:0] MOTOR_ENCODER_POS,
   // capture unit
   input  wire logic        CAPTURE_DONE,
   output var  logic        CAPTURE_ENABLE,
   output var  logic [3:0]  CAPTURE_AXIS_SOURCE,
   output var  logic [15:0] CAPTURE_COUNT_LOAD,
   output var  logic        CAPTURE_LOAD,
   // outputs
   output var  logic        FAST_COMPARE_OUTPUT,
   output var  logic        TASK_START,
   output var  logic [6:0]  TASK_NUMBER,
   output var  logic        QUAD_A,
   output var  logic        QUAD_B
);

   localparam int unsigned IW = $clog2(ARRAY_DEPTH);

   typedef struct packed
   {
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic               aw_got;
      logic               w_got;
      logic [7:0]         waddr;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic [31:0]        control;
      logic [IW-1:0]      start;
      logic [31:0]        offset;
      logic [15:0]        remaining;
      logic [15:0]        setting;
      logic [31:0]        cap_control;
      logic [15:0]        cap_count;
      logic [31:0]        resolution;
      logic [31:0]        divisor;
      logic [IW-1:0]      arr_index;
      logic               user_level;
      logic               done;
      seq_state_e         state;
      logic [IW-1:0]      cursor;
      logic [31:0]        prev_pos;
      logic               pulse_on;
      logic [11:0]        pulse_ms;
      logic [31:0]        pulse_cyc;
      logic               fast_out;
      logic               task_start;
      logic [6:0]         task_num;
      logic               cap_load;
      logic [31:0]        prev_motor;
      logic signed [65:0] acc;
      logic [1:0]         quad;
   } unit_state_s;

   unit_state_s r;
   unit_state_s n;

   logic [31:0] target_mem [ARRAY_DEPTH];
   logic        mem_we;
   logic [31:0] mem_wdata;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            m[8*b +: 8] = d[8*b +: 8];
         end
      end
      return m;
   endfunction : merge_strb

   // gray step of the quadrature pair, forward 00-01-11-10
   function automatic logic [1:0] quad_step(input logic [1:0] q, input logic up);
      logic [1:0] s;
      s = q;
      case ({q, up})
         3'b001:  s = 2'b01;
         3'b011:  s = 2'b11;
         3'b111:  s = 2'b10;
         3'b101:  s = 2'b00;
         3'b000:  s = 2'b10;
         3'b100:  s = 2'b11;
         3'b110:  s = 2'b01;
         3'b010:  s = 2'b00;
         default: s = q;
      endcase
      return s;
   endfunction : quad_step

   function automatic logic [IW-1:0] next_index(input logic [IW-1:0] i);
      logic [IW-1:0] k;
      k = (32'(i) >= ARRAY_DEPTH - 1) ? '0 : IW'(32'(i) + 1);
      return k;
   endfunction : next_index

   // ****************************************
   // next state
   // ****************************************
   logic [31:0]        sel_pos;
   logic [31:0]        axis_pos;
   logic [31:0]        target;
   logic               match;
   logic               last;
   logic               do_write;
   logic [31:0]        wval;
   logic [31:0]        rval;
   logic [1:0]         rresp_v;
   logic [31:0]        motor_delta;
   logic [65:0]        num;
   logic [65:0]        den;
   logic signed [65:0] acc_up;
   logic signed [65:0] acc_dn;

   always_comb
   begin
      n         = r;
      mem_we    = 1'b0;
      mem_wdata = '0;
      rval      = '0;
      rresp_v   = `RESP_OKAY;
      wval      = '0;
      n.task_start = 1'b0;
      n.cap_load   = 1'b0;

      case (axis_source_e'(r.control[`CTL_SOURCE_LSB +: 4]))
         SRC_CAPTURE: sel_pos = CAPTURE_AXIS_POS;
         SRC_AUX:     sel_pos = AUX_ENCODER_POS;
         SRC_PULSE:   sel_pos = PULSE_COMMAND_POS;
         SRC_MOTOR:   sel_pos = MOTOR_ENCODER_POS;
         default:     sel_pos = CAPTURE_AXIS_POS;
      endcase
      axis_pos = sel_pos - r.offset;
      target   = target_mem[r.cursor];
      // crossing as well as equality, so a fast axis that jumps over the target still fires
      match = (r.state == SEQ_RUN) && (r.remaining != 16'h0000) &&
              ((axis_pos == target) ||
               ($signed(r.prev_pos) < $signed(target) && $signed(axis_pos) > $signed(target)) ||
               ($signed(r.prev_pos) > $signed(target) && $signed(axis_pos) < $signed(target)));
      last = match && (r.remaining == 16'h0001);
      n.prev_pos = axis_pos;

      // sequencer
      case (r.state)
         SEQ_IDLE:
         begin
            if (r.control[`CTL_ENABLE_BIT] && r.remaining != 16'h0000)
            begin
               n.state  = SEQ_RUN;
               n.cursor = r.start;
            end
         end
         SEQ_RUN:
         begin
            if (!r.control[`CTL_ENABLE_BIT])
            begin
               n.state = SEQ_IDLE;
            end
            else if (match)
            begin
               n.cursor    = next_index(r.cursor);
               n.remaining = r.remaining - 16'h0001;
               if (last)
               begin
                  n.done = 1'b1;
                  if (r.control[`CTL_CLEAR_AXIS_BIT])
                  begin
                     n.offset   = sel_pos;
                     n.prev_pos = '0;
                  end
                  if (r.control[`CTL_ARM_CAPTURE_BIT] && !r.cap_control[`CAP_ENABLE_BIT])
                  begin
                     n.cap_load = 1'b1;
                  end
                  if (r.control[`CTL_TASK_LSB +: 4] == 4'h1)
                  begin
                     n.task_start = 1'b1;
                     n.task_num   = `TASK_FIRST;
                  end
                  else if (r.control[`CTL_TASK_LSB +: 4] == 4'h2)
                  begin
                     n.task_start = 1'b1;
                     n.task_num   = `TASK_SECOND;
                  end
                  if (r.control[`CTL_CYCLIC_BIT])
                  begin
                     n.remaining = r.setting;
                     n.cursor    = r.start;
                  end
                  else
                  begin
                     n.state = SEQ_FINISHED;
                  end
               end
            end
         end
         SEQ_FINISHED:
         begin
            if (!r.control[`CTL_ENABLE_BIT])
            begin
               n.state = SEQ_IDLE;
            end
            else if (r.remaining != 16'h0000)
            begin
               n.state  = SEQ_RUN;
               n.cursor = r.start;
            end
         end
         default:
         begin
            n.state = SEQ_IDLE;
         end
      endcase

      // pulse timer; a new match restarts it
      if (match)
      begin
         n.pulse_on  = 1'b1;
         n.pulse_ms  = r.control[`CTL_DURATION_LSB +: 12];
         n.pulse_cyc = (r.control[`CTL_DURATION_LSB +: 12] == 12'h000) ? '0 : MS_CYCLES - 1;
      end
      else if (r.pulse_on)
      begin
         if (r.pulse_cyc != 32'h0000_0000)
         begin
            n.pulse_cyc = r.pulse_cyc - 32'h0000_0001;
         end
         else if (r.pulse_ms <= 12'h001)
         begin
            n.pulse_on = 1'b0;
         end
         else
         begin
            n.pulse_ms  = r.pulse_ms - 12'h001;
            n.pulse_cyc = MS_CYCLES - 1;
         end
      end
      n.fast_out = r.control[`CTL_ENABLE_BIT] ?
                   (n.pulse_on ^ r.control[`CTL_POLARITY_BIT]) : r.user_level;

      // encoder pulse output; assumes scaled rate never exceeds one edge per motor count
      motor_delta  = MOTOR_ENCODER_POS - r.prev_motor;
      n.prev_motor = MOTOR_ENCODER_POS;
      num    = 66'(r.resolution) << 2;
      den    = 66'(COUNTS_PER_REV) * ((r.divisor == '0) ? 66'd1 : 66'(r.divisor));
      acc_up = r.acc + $signed(num);
      acc_dn = r.acc - $signed(num);
      if (r.control[`CTL_SOURCE_LSB +: 4] == SRC_MOTOR && den != '0)
      begin
         if (motor_delta == 32'h0000_0001)
         begin
            if (acc_up >= $signed(den))
            begin
               n.acc  = acc_up - $signed(den);
               n.quad = quad_step(r.quad, 1'b1);
            end
            else
            begin
               n.acc = acc_up;
            end
         end
         else if (motor_delta == 32'hFFFF_FFFF)
         begin
            if (acc_dn < 0)
            begin
               n.acc  = acc_dn + $signed(den);
               n.quad = quad_step(r.quad, 1'b0);
            end
            else
            begin
               n.acc = acc_dn;
            end
         end
      end

      // capture unit handshake: arming wins over the done clear
      if (CAPTURE_DONE)
      begin
         n.cap_control[`CAP_ENABLE_BIT] = 1'b0;
      end
      if (n.cap_load)
      begin
         n.cap_control[`CAP_ENABLE_BIT] = 1'b1;
      end

      // axi write channel
      if (r.bvalid && S_AXI_BREADY)
      begin
         n.bvalid = 1'b0;
      end
      if (S_AXI_AWVALID && r.awready)
      begin
         n.aw_got = 1'b1;
         n.waddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && r.wready)
      begin
         n.w_got = 1'b1;
         n.wdata = S_AXI_WDATA;
         n.wstrb = S_AXI_WSTRB;
      end
      do_write = r.aw_got && r.w_got && !r.bvalid;
      if (do_write)
      begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `RESP_OKAY;
         case (r.waddr & 8'hFC)
            `OFS_CONTROL:
            begin
               n.control = merge_strb(r.control, r.wdata, r.wstrb);
            end
            `OFS_START_INDEX:
            begin
               wval    = merge_strb(32'(r.start), r.wdata, r.wstrb);
               n.start = IW'(wval);
            end
            `OFS_AXIS_POSITION:
            begin
               wval     = merge_strb(axis_pos, r.wdata, r.wstrb);
               n.offset = sel_pos - wval;
               n.prev_pos = wval;
            end
            `OFS_REMAINING:
            begin
               wval        = merge_strb(32'(r.setting), r.wdata, r.wstrb);
               n.remaining = wval[15:0];
               n.setting   = wval[15:0];
               n.cursor    = r.start;
            end
            `OFS_CAPTURE_CONTROL:
            begin
               wval = merge_strb(r.cap_control, r.wdata, r.wstrb);
               if (r.control[`CTL_SOURCE_LSB +: 4] == SRC_CAPTURE)
               begin
                  wval[`CAP_SOURCE_LSB +: 4] = r.cap_control[`CAP_SOURCE_LSB +: 4];
               end
               wval[`CAP_ENABLE_BIT] = wval[`CAP_ENABLE_BIT] | n.cap_load;
               n.cap_control = wval;
            end
            `OFS_CAPTURE_COUNT:
            begin
               wval        = merge_strb(32'(r.cap_count), r.wdata, r.wstrb);
               n.cap_count = wval[15:0];
            end
            `OFS_OUT_RESOLUTION: n.resolution = merge_strb(r.resolution, r.wdata, r.wstrb);
            `OFS_OUT_DIVISOR:    n.divisor    = merge_strb(r.divisor, r.wdata, r.wstrb);
            `OFS_ARRAY_INDEX:
            begin
               wval        = merge_strb(32'(r.arr_index), r.wdata, r.wstrb);
               n.arr_index = IW'(wval);
            end
            `OFS_ARRAY_DATA:
            begin
               if (32'(r.arr_index) < ARRAY_DEPTH)
               begin
                  mem_we      = 1'b1;
                  mem_wdata   = merge_strb(target_mem[r.arr_index], r.wdata, r.wstrb);
                  n.arr_index = IW'(32'(r.arr_index) + 1);
               end
               else
               begin
                  n.bresp = `RESP_SLVERR;
               end
            end
            `OFS_STATUS:
            begin
               if (r.wstrb[0] && r.wdata[`STS_DONE_BIT] && !n.done)
               begin
                  n.done = 1'b0;
               end
               else if (r.wstrb[0] && r.wdata[`STS_DONE_BIT] && !last)
               begin
                  n.done = 1'b0;
               end
            end
            `OFS_USER_OUTPUT:
            begin
               if (r.wstrb[0])
               begin
                  n.user_level = r.wdata[0];
               end
            end
            default: n.bresp = `RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;

      // axi read channel; reading array data steps the index
      if (r.rvalid && S_AXI_RREADY)
      begin
         n.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && r.arready)
      begin
         case (S_AXI_ARADDR & 8'hFC)
            `OFS_CONTROL:         rval = r.control;
            `OFS_START_INDEX:     rval = 32'(r.start);
            `OFS_AXIS_POSITION:   rval = axis_pos;
            `OFS_REMAINING:       rval = 32'(r.remaining);
            `OFS_CAPTURE_CONTROL: rval = r.cap_control;
            `OFS_CAPTURE_COUNT:   rval = 32'(r.cap_count);
            `OFS_OUT_RESOLUTION:  rval = r.resolution;
            `OFS_OUT_DIVISOR:     rval = r.divisor;
            `OFS_ARRAY_INDEX:     rval = 32'(r.arr_index);
            `OFS_ARRAY_DATA:
            begin
               if (32'(r.arr_index) < ARRAY_DEPTH && !do_write)
               begin
                  rval        = target_mem[r.arr_index];
                  n.arr_index = IW'(32'(r.arr_index) + 1);
               end
               else
               begin
                  rresp_v = `RESP_SLVERR;
               end
            end
            `OFS_STATUS:
               rval = {6'h00, 10'(r.cursor), 13'h0000, r.done, r.fast_out, (r.state == SEQ_RUN)};
            `OFS_USER_OUTPUT:     rval = {31'h0000_0000, r.user_level};
            default:              rresp_v = `RESP_SLVERR;
         endcase
         n.rvalid = 1'b1;
         n.rdata  = rval;
         n.rresp  = rresp_v;
      end
      n.arready = !n.rvalid;
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         r         <= '0;
         r.awready <= 1'b1;
         r.wready  <= 1'b1;
         r.arready <= 1'b1;
         r.state   <= SEQ_IDLE;
      end
      else if (CE)
      begin
         r <= n;
      end
   end

   // array has no reset: contents are volatile and written by software before use
   always_ff @(posedge REF_CLK)
   begin
      if (CE && mem_we)
      begin
         target_mem[r.arr_index] <= mem_wdata;
      end
   end

   assign S_AXI_AWREADY       = r.awready;
   assign S_AXI_WREADY        = r.wready;
   assign S_AXI_BRESP         = r.bresp;
   assign S_AXI_BVALID        = r.bvalid;
   assign S_AXI_ARREADY       = r.arready;
   assign S_AXI_RDATA         = r.rdata;
   assign S_AXI_RRESP         = r.rresp;
   assign S_AXI_RVALID        = r.rvalid;
   assign CAPTURE_ENABLE      = r.cap_control[`CAP_ENABLE_BIT];
   assign CAPTURE_AXIS_SOURCE = r.cap_control[`CAP_SOURCE_LSB +: 4];
   assign CAPTURE_COUNT_LOAD  = r.cap_count;
   assign CAPTURE_LOAD        = r.cap_load;
   assign FAST_COMPARE_OUTPUT = r.fast_out;
   assign TASK_START          = r.task_start;
   assign TASK_NUMBER         = r.task_num;
   assign QUAD_A              = r.quad[1];
   assign QUAD_B              = r.quad[0];

endmodule : position_compare_pulse_unit

`default_nettype wire

// File: position_source_model.sv
// Purpose: far-side position source for the compare unit
// Assumes: one count per cycle while step is high
// Notes:   all four axes share one counter
`timescale 1ns/1ns
`default_nettype none
module position_source_model
(
   // clock, reset, motion request
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        step,
   // shared position
   output var  logic [31:0] pos
);
   // single steps keep match crossings exact
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) pos <= 32'h0000_0000;
      else if (step) pos <= pos + 32'h0000_0001;
endmodule : position_source_model
`default_nettype wire

// File: position_compare_properties.sv
// Purpose: port checks of the compare unit
// Assumes: CE held high
// Notes:   bound from the testbench
`timescale 1ns/1ns
`default_nettype none
module position_compare_checker
(
   input wire logic        REF_CLK, RST_N, CE,
   input wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
   input wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID, S_AXI_RREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        TASK_START, CAPTURE_ENABLE, CAPTURE_LOAD, QUAD_A, QUAD_B,
   input wire logic [6:0]  TASK_NUMBER
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CE;
   endsequence
   sequence s_rd_taken;
      S_AXI_ARVALID && S_AXI_ARREADY && CE;
   endsequence
   chk_write_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID) else $error("no write answer");
   chk_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID) else $error("no read answer");
   chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer dropped");
   chk_task_number: assert property (TASK_START |-> TASK_NUMBER inside {7'h32, 7'h3C})
      else $error("bad task number");
   chk_task_pulse: assert property (TASK_START |=> !TASK_START) else $error("task start too long");
   chk_arm_enable: assert property (CAPTURE_LOAD |-> CAPTURE_ENABLE && !$past(CAPTURE_ENABLE))
      else $error("capture arm wrong");
   chk_arm_pulse: assert property (CAPTURE_LOAD |=> !CAPTURE_LOAD) else $error("capture load too long");
   chk_quad_gray: assert property ($changed(QUAD_A) |-> $stable(QUAD_B)) else $error("quadrature jump");
endmodule : position_compare_checker
`default_nettype wire

// File: tb_position_compare_pulse_unit.sv
// Purpose: register-level tests of the compare unit
// Assumes: short millisecond and revolution counts
// Notes:   positions come from the source model
`include "compare_unit_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_position_compare_pulse_unit;
   logic        c, rn, av, wv, br, arv, rr, step, aw_r, w_r, bv, ar_r, rv, ts, cen, cl, fo, qa, qb, fp;
   logic [7:0]  aa, ra;
   logic [31:0] wd, pos, rdt;
   logic [1:0]  brs, rrs, qp;
   logic [6:0]  tn;
   logic [3:0]  cs;
   logic [15:0] ccl;
   int          errors, tests_run, np, nq, ncl, cyc, nh;
   position_compare_pulse_unit #(.MS_CYCLES(5), .COUNTS_PER_REV(4)) position_compare_pulse_unit_i (
      .REF_CLK(c), .RST_N(rn), .CE(1'h1), .S_AXI_AWADDR(aa), .S_AXI_AWVALID(av), .S_AXI_AWREADY(aw_r),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r), .S_AXI_BRESP(brs),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_r),
      .S_AXI_RDATA(rdt), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .CAPTURE_AXIS_POS(pos),
      .AUX_ENCODER_POS(pos), .PULSE_COMMAND_POS(pos), .MOTOR_ENCODER_POS(pos), .CAPTURE_DONE(1'h0),
      .CAPTURE_ENABLE(cen), .CAPTURE_AXIS_SOURCE(cs), .CAPTURE_COUNT_LOAD(ccl), .CAPTURE_LOAD(cl),
      .FAST_COMPARE_OUTPUT(fo), .TASK_START(ts), .TASK_NUMBER(tn), .QUAD_A(qa), .QUAD_B(qb));
   position_source_model position_source_model_i (.clk(c), .rst_n(rn), .step(step), .pos(pos));
   initial begin c = 1'h0; forever #20 c = ~c; end
   always @(posedge c)
   begin
      fp <= fo; qp <= {qa, qb}; cyc++;
      if (fo && !fp) np++;
      if ({qa, qb} !== qp) nq++;
      if (cl) ncl++;
      if (fo) nh++;
      if (cyc == 20000) begin errors++; finish_test; end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin errors++; $display("unexpected at %0t: got %h want %h", $time, g, e); end
   endtask : chk
   task settle; repeat (3) @(negedge c); endtask : settle
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge c); aa <= a; wd <= d; av <= 1'h1; wv <= 1'h1; br <= 1'h1;
      do begin @(posedge c); if (aw_r) av <= 1'h0; if (w_r) wv <= 1'h0; end while ((av && !aw_r) || (wv && !w_r));
      do @(posedge c); while (!bv);
      br <= 1'h0; chk(brs, e);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge c); ra <= a; arv <= 1'h1; rr <= 1'h1;
      do @(posedge c); while (!ar_r);
      arv <= 1'h0;
      do @(posedge c); while (!rv);
      rr <= 1'h0; chk(rrs, er);
      if (er == 2'h0) chk(rdt, e);
   endtask : rd
   task finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      {rn, av, wv, br, arv, rr, step, aa, ra, wd} = '0;
      {errors, tests_run, np, nq, ncl, cyc, nh} = '0;
      repeat (20) @(posedge c); rn <= 1'h1;
      rd(`OFS_CONTROL, `RST_WORD, `RESP_OKAY);
      rd(8'h3C, 32'h0000_0000, `RESP_SLVERR);
      wr(`OFS_ARRAY_INDEX, 32'h0000_0000, `RESP_OKAY); wr(`OFS_ARRAY_DATA, 32'h0000_0028, `RESP_OKAY);
      wr(`OFS_ARRAY_DATA, 32'h0000_0050, `RESP_OKAY); wr(`OFS_ARRAY_INDEX, 32'h0000_0320, `RESP_OKAY);
      wr(`OFS_ARRAY_DATA, 32'h0000_0005, `RESP_SLVERR);
      $display("test registers done");
      wr(`OFS_START_INDEX, 32'h0000_0000, `RESP_OKAY); wr(`OFS_REMAINING, 32'h0000_0002, `RESP_OKAY);
      wr(`OFS_CAPTURE_COUNT, 32'h0000_0003, `RESP_OKAY); wr(`OFS_CONTROL, 32'h0001_101D, `RESP_OKAY);
      step <= 1'h1;
      do @(posedge c); while (!ts);
      step <= 1'h0; chk(32'(tn), 32'h0000_0032);
      settle; chk(32'(np), 32'h0000_0002);
      chk(32'(ncl), 32'h0000_0001); chk(32'(ccl), 32'h0000_0003); chk(32'(cen), 32'h0000_0001);
      rd(`OFS_REMAINING, 32'h0000_0000, `RESP_OKAY);
      rd(`OFS_AXIS_POSITION, 32'h0000_0002, `RESP_OKAY);
      chk(32'(nh), 32'h0000_000A);
      $display("test compare run done");
      wr(`OFS_USER_OUTPUT, 32'h0000_0001, `RESP_OKAY); wr(`OFS_CONTROL, 32'h0000_0001, `RESP_OKAY);
      settle; chk(32'(fo), 32'h0000_0000);
      wr(`OFS_CONTROL, 32'h0000_0101, `RESP_OKAY); settle; chk(32'(fo), 32'h0000_0001);
      wr(`OFS_CAPTURE_CONTROL, 32'h0000_0051, `RESP_OKAY); settle; chk(32'(cs), 32'h0000_0000);
      wr(`OFS_CONTROL, 32'h0000_0000, `RESP_OKAY); settle; chk(32'(fo), 32'h0000_0001);
      $display("test output ownership done");
      wr(`OFS_OUT_RESOLUTION, 32'h0000_0001, `RESP_OKAY); wr(`OFS_CONTROL, 32'h0000_0031, `RESP_OKAY);
      for (int k = 0; k < 2; k++)
      begin
         wr(`OFS_OUT_DIVISOR, 32'(2 * k), `RESP_OKAY); settle; nq = 0;
         @(posedge c); step <= 1'h1;
         repeat (8) @(posedge c); step <= 1'h0;
         settle; chk(32'(nq), (k == 0) ? 32'h0000_0008 : 32'h0000_0004);
      end
      $display("test quadrature done");
      wr(`OFS_REMAINING, 32'h0000_0001, `RESP_OKAY); wr(`OFS_CONTROL, 32'h0000_2023, `RESP_OKAY);
      step <= 1'h1;
      do @(posedge c); while (!ts);
      step <= 1'h0; chk(32'(tn), 32'h0000_003C);
      rd(`OFS_REMAINING, 32'h0000_0001, `RESP_OKAY);
      $display("test cyclic done");
      finish_test;
   end
endmodule : tb_position_compare_pulse_unit
bind position_compare_pulse_unit position_compare_checker position_compare_checker_i (.*);
`default_nettype wire
